// ---- rtl/flash_ctl_pkg.sv ----
// package for the flash program/erase sequencer: offsets, fields, timing.
// assumes a 32-bit avalon-mm register slave with word addressing by byte.
package flash_ctl_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_TARGET_ADDRESS = 8'h00;
   localparam logic [7:0] OFS_WRITE_DATA = 8'h04;
   localparam logic [7:0] OFS_COMMAND = 8'h08;
   localparam logic [7:0] OFS_RAW_STATUS = 8'h0c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
   // field layout
   localparam int OFFSET_WIDTH = 14;
   localparam logic [15:0] COMMAND_KEY = 16'ha442;
   localparam int BIT_PROGRAM = 0;
   localparam int BIT_PAGE_ERASE = 1;
   localparam int BIT_FULL_ERASE = 2;
   localparam int BIT_COMMIT = 3;
   localparam int BIT_DONE_FLAG = 1;
   localparam logic [13:0] WORD_ALIGN_MASK = 14'h0003;
   localparam logic [13:0] PAGE_ALIGN_MASK = 14'h03ff;
   // reset values
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   // timing, 50 MHz clock
   localparam int CLK_MHZ = 50;
   localparam int PROGRAM_TIME_US = 50;
   localparam int COMMIT_TIME_US = 50;
   localparam int PAGE_ERASE_TIME_MS = 25;
   localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLK_MHZ;
   localparam int COMMIT_CYCLES = COMMIT_TIME_US * CLK_MHZ;
   localparam int PAGE_ERASE_CYCLES = PAGE_ERASE_TIME_MS * 1000 * CLK_MHZ;
   localparam int FULL_ERASE_CYCLES = 2 * PAGE_ERASE_CYCLES;
   localparam int COUNT_WIDTH = 24;
endpackage

// ---- rtl/flash_program_erase_control.sv ----
// flash program/erase sequencer with avalon-mm registers and interrupt.
// assumes the array port answers o_arr_* requests; busy time is counted
// here, so the array only needs to accept the strobe.
//
// Operation
// - program uses the address register as a word-aligned target.
// - page erase uses the address register as a 1 KB aligned page.
// - address register: 14-bit writable offset, upper bits read zero.
// - data register is 32-bit read/write, reset zero, word to program.
// - data register may be undefined after execute-only block reads; here only bus writes change it.
// - erases ignore the data register entirely.
// - keyed command write starts the cycle at the address register.
// - command writes act only with key 0xA442 in bits 31:16.
// - the command key field always reads as zero.
// - bit 3 commits protection values; reads 1 up to 50 us.
// - bit 2 erases the whole array; reads 1 while in progress.
// - bit 1 erases the addressed page; reads 1 up to 25 ms.
// - bit 0 programs the data word; reads 1 up to 50 us.
// - writing zero to an operation bit changes nothing.
// - finished program or erase sets the raw done flag.
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control #(
   parameter int PAGE_ERASE_COUNT = flash_ctl_pkg::PAGE_ERASE_CYCLES,
   parameter int FULL_ERASE_COUNT = flash_ctl_pkg::FULL_ERASE_CYCLES
) (
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // avalon-mm slave
   input wire logic [7:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [3:0] i_byteenable,
   input wire logic [31:0] i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // flash array port
   output logic o_arr_program,
   output logic o_arr_page_erase,
   output logic o_arr_full_erase,
   output logic o_arr_commit,
   output logic [13:0] o_arr_offset,
   output logic [31:0] o_arr_data,
   // interrupt
   output logic o_irq
);
   typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DONE} seq_state_t;

   logic [13:0] target_address_reg;
   logic [31:0] write_data_reg;
   logic [3:0] op_busy_reg;
   logic [23:0] count_reg;
   seq_state_t state_reg;
   logic done_flag_reg;
   logic done_mask_reg;
   logic ack_reg;
   logic [31:0] readdata_reg;
   logic [3:0] strobe_reg;

   logic access;
   logic wr_take;
   logic rd_take;
   logic cmd_valid;
   logic [3:0] cmd_ops;
   logic finish;
   logic [23:0] load_count;
   logic take_edge;
   logic start;
   logic clear_done;
   logic [31:0] address_merged;
   logic [31:0] read_value;

   // apply byte enables to a 32-bit register value
   function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   // true when the bus address selects the given register
   function automatic logic reg_hit(input logic [7:0] addr,
                                    input logic [7:0] ofs);
      return addr == ofs;
   endfunction

   // busy time of the lowest set operation bit; several bits at once are
   // a software error, so this only keeps the sequencer well defined
   function automatic logic [23:0] op_cycles(input logic [3:0] ops);
      logic [23:0] c;
      c = 24'h00_0000;
      if (ops[flash_ctl_pkg::BIT_PROGRAM]) begin
         c = 24'(flash_ctl_pkg::PROGRAM_CYCLES);
      end else if (ops[flash_ctl_pkg::BIT_PAGE_ERASE]) begin
         c = 24'(PAGE_ERASE_COUNT);
      end else if (ops[flash_ctl_pkg::BIT_FULL_ERASE]) begin
         c = 24'(FULL_ERASE_COUNT);
      end else if (ops[flash_ctl_pkg::BIT_COMMIT]) begin
         c = 24'(flash_ctl_pkg::COMMIT_CYCLES);
      end
      return c;
   endfunction

   // one wait state: writes land on the second edge, reads are fetched
   // on the first so the word already stands when waitrequest drops;
   // a low enable stretches the wait instead of losing the access
   assign access = i_read | i_write;
   assign take_edge = ack_reg & i_ce;
   assign o_waitrequest = access & ~take_edge;
   assign wr_take = i_write & take_edge;
   assign rd_take = i_read & ~ack_reg & i_ce;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ack_reg <= 1'b0;
      end else if (i_ce) begin
         ack_reg <= access & ~ack_reg;
      end
   end

   // key and full byte lanes of the key field are required
   assign cmd_valid = wr_take && i_address == flash_ctl_pkg::OFS_COMMAND
      && i_byteenable[3:2] == 2'b11 && i_byteenable[0]
      && i_writedata[31:16] == flash_ctl_pkg::COMMAND_KEY;
   // zero bits are ignored, and nothing starts while busy
   assign cmd_ops = (cmd_valid && state_reg == ST_IDLE)
      ? i_writedata[3:0] : 4'h0;

   assign load_count = op_cycles(cmd_ops);

   // address register, low 14 bits writable
   assign address_merged = merge_be({18'h0, target_address_reg},
      i_writedata, i_byteenable);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         target_address_reg <= '0;
      end else if (wr_take
            && reg_hit(i_address, flash_ctl_pkg::OFS_TARGET_ADDRESS)) begin
         target_address_reg <= address_merged[13:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         write_data_reg <= flash_ctl_pkg::RESET_WORD;
      end else if (wr_take
            && reg_hit(i_address, flash_ctl_pkg::OFS_WRITE_DATA)) begin
         // only bus writes change the word, so it never goes undefined
         write_data_reg <= merge_be(write_data_reg, i_writedata,
            i_byteenable);
      end
   end

   // sequencer: busy bits hold until the cycle count runs out; state,
   // count and busy bits each have their own process
   assign start = load_count != 24'h00_0000;
   assign finish = state_reg == ST_BUSY && count_reg == 24'h00_0001;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_reg <= ST_IDLE;
      end else if (i_ce) begin
         case (state_reg)
            ST_IDLE: begin
               if (start) begin
                  state_reg <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               if (finish) begin
                  state_reg <= ST_DONE;
               end
            end
            ST_DONE: begin
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // busy time is counted here, so the array needs no done signal
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         count_reg <= '0;
      end else if (i_ce) begin
         if (state_reg == ST_IDLE && start) begin
            count_reg <= load_count;
         end else if (state_reg == ST_BUSY) begin
            count_reg <= count_reg - 24'h00_0001;
         end
      end
   end

   // busy bits read back as one until the operation has finished
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         op_busy_reg <= 4'h0;
      end else if (i_ce) begin
         if (state_reg == ST_IDLE && start) begin
            op_busy_reg <= cmd_ops;
         end else if (state_reg == ST_DONE) begin
            op_busy_reg <= 4'h0;
         end
      end
   end

   // array strobes: one cycle at start
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         strobe_reg <= 4'h0;
      end else if (i_ce) begin
         strobe_reg <= cmd_ops;
      end
   end

   // target captured with the strobe, aligned to the operation
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_arr_offset <= '0;
      end else if (i_ce) begin
         if (cmd_ops[flash_ctl_pkg::BIT_PROGRAM]) begin
            o_arr_offset <= target_address_reg
               & ~flash_ctl_pkg::WORD_ALIGN_MASK;
         end else if (cmd_ops[flash_ctl_pkg::BIT_PAGE_ERASE]) begin
            o_arr_offset <= target_address_reg
               & ~flash_ctl_pkg::PAGE_ALIGN_MASK;
         end
      end
   end

   // erases leave the data output alone
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_arr_data <= '0;
      end else if (i_ce && cmd_ops[flash_ctl_pkg::BIT_PROGRAM]) begin
         o_arr_data <= write_data_reg;
      end
   end

   assign o_arr_program = strobe_reg[flash_ctl_pkg::BIT_PROGRAM];
   assign o_arr_page_erase = strobe_reg[flash_ctl_pkg::BIT_PAGE_ERASE];
   assign o_arr_full_erase = strobe_reg[flash_ctl_pkg::BIT_FULL_ERASE];
   assign o_arr_commit = strobe_reg[flash_ctl_pkg::BIT_COMMIT];

   // write-one clear of the done flag through the masked status register
   assign clear_done = wr_take
      && reg_hit(i_address, flash_ctl_pkg::OFS_IRQ_STATUS)
      && i_byteenable[0]
      && i_writedata[flash_ctl_pkg::BIT_DONE_FLAG];

   // done flag: set wins over the write-one clear, so a finish that
   // meets a clear is never lost
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         done_flag_reg <= 1'b0;
      end else if (i_ce) begin
         if (finish && op_busy_reg[2:0] != 3'b000) begin
            done_flag_reg <= 1'b1;
         end else if (clear_done) begin
            done_flag_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         done_mask_reg <= 1'b0;
      end else if (wr_take
            && reg_hit(i_address, flash_ctl_pkg::OFS_IRQ_MASK)
            && i_byteenable[0]) begin
         done_mask_reg <= i_writedata[flash_ctl_pkg::BIT_DONE_FLAG];
      end
   end

   assign o_irq = done_flag_reg & done_mask_reg;

   // read mux; key field and unmapped offsets read zero
   always_comb begin
      read_value = 32'h0000_0000;
      case (i_address)
         flash_ctl_pkg::OFS_TARGET_ADDRESS: begin
            read_value = {18'h0, target_address_reg};
         end
         flash_ctl_pkg::OFS_WRITE_DATA: begin
            read_value = write_data_reg;
         end
         flash_ctl_pkg::OFS_COMMAND: begin
            read_value = {28'h000_0000, op_busy_reg};
         end
         flash_ctl_pkg::OFS_RAW_STATUS: begin
            read_value = {30'h0, done_flag_reg, 1'b0};
         end
         flash_ctl_pkg::OFS_IRQ_MASK: begin
            read_value = {30'h0, done_mask_reg, 1'b0};
         end
         flash_ctl_pkg::OFS_IRQ_STATUS: begin
            read_value = {30'h0, o_irq, 1'b0};
         end
         default: begin
            read_value = 32'h0000_0000;
         end
      endcase
   end

   // fetched in the wait cycle, so the word stands at the answering edge
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         readdata_reg <= '0;
      end else if (rd_take) begin
         readdata_reg <= read_value;
      end
   end

   assign o_readdata = readdata_reg;
endmodule
`default_nettype wire

// ---- testbench/flash_ctl_monitor.sv ----
// checker for the flash sequencer: key gate, strobes and register reads.
// assumes full byte enables; shadow copies follow address and data.
`timescale 1ns/1ps
`default_nettype none
module flash_ctl_monitor (
   // clock and bus
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic [7:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [31:0] o_readdata,
   input wire logic o_waitrequest,
   // array port
   input wire logic o_arr_program,
   input wire logic o_arr_page_erase,
   input wire logic o_arr_full_erase,
   input wire logic o_arr_commit,
   input wire logic [13:0] o_arr_offset,
   input wire logic [31:0] o_arr_data
);
   logic wr_ok, rd_ok, at_cmd, keyed, any_op;
   logic [3:0] cb;
   logic [13:0] addr_m;
   logic [31:0] data_m;
   assign wr_ok = i_write && !o_waitrequest && i_ce;
   assign rd_ok = i_read && !o_waitrequest && i_ce;
   assign at_cmd = i_address == flash_ctl_pkg::OFS_COMMAND;
   assign keyed = wr_ok && at_cmd
      && i_writedata[31:16] == flash_ctl_pkg::COMMAND_KEY;
   assign cb = i_writedata[3:0] & {4{keyed}};
   assign any_op = o_arr_program || o_arr_page_erase || o_arr_full_erase
      || o_arr_commit;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         addr_m <= '0;
         data_m <= '0;
      end else if (wr_ok && i_address == flash_ctl_pkg::OFS_TARGET_ADDRESS) begin
         addr_m <= i_writedata[13:0];
      end else if (wr_ok && i_address == flash_ctl_pkg::OFS_WRITE_DATA) begin
         data_m <= i_writedata;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_key_gate: assert property (
      wr_ok && at_cmd && !keyed |=> !any_op) else $error("unkeyed strobe");
   a_prog_cause: assert property (
      o_arr_program |-> $past(cb[0])) else $error("stray program");
   a_erase_cause: assert property (
      o_arr_page_erase |-> $past(cb[1])) else $error("stray page erase");
   a_mass_cause: assert property (
      o_arr_full_erase |-> $past(cb[2])) else $error("stray mass erase");
   a_commit_cause: assert property (
      o_arr_commit |-> $past(cb[3])) else $error("stray commit");
   a_prog_word: assert property (
      o_arr_program |-> o_arr_data == data_m && o_arr_offset == addr_m)
      else $error("program target wrong");
   a_page_sel: assert property (
      o_arr_page_erase |-> o_arr_offset == addr_m) else $error("page wrong");
   a_key_reads0: assert property (
      rd_ok && at_cmd |-> o_readdata[31:16] == 16'h0000)
      else $error("key readable");
   a_addr_read: assert property (
      rd_ok && i_address == flash_ctl_pkg::OFS_TARGET_ADDRESS
      |-> o_readdata == {18'h0, addr_m}) else $error("address read");
endmodule
bind flash_program_erase_control flash_ctl_monitor u_flash_ctl_monitor (
   .i_clk, .i_rst_n, .i_ce, .i_address, .i_read, .i_write, .i_writedata,
   .o_readdata, .o_waitrequest, .o_arr_program, .o_arr_page_erase,
   .o_arr_full_erase, .o_arr_commit, .o_arr_offset, .o_arr_data);
`default_nettype wire

// ---- testbench/flash_array_model.sv ----
// flash array stand-in: counts strobes and keeps the last target.
// assumes one-cycle strobes; timing is owned by the sequencer.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
   // sequencer side
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_strobe,
   input wire logic [13:0] i_offset,
   input wire logic [31:0] i_data,
   // observation
   output logic [31:0] o_counts,
   output logic [13:0] o_offset,
   output logic [31:0] o_data
);
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_counts <= '0;
         o_offset <= '0;
         o_data <= '0;
      end else begin
         for (int k = 0; k < 4; k++) begin
            o_counts[k*8 +: 8] <= o_counts[k*8 +: 8] + 8'(i_strobe[k]);
         end
         if (i_strobe[1:0] != 2'b00) begin
            o_offset <= i_offset;
         end
         // erases leave the stored word alone
         if (i_strobe[0]) begin
            o_data <= i_data;
         end
      end
   end
endmodule
`default_nettype wire

// ---- testbench/test_flash_program_erase_control.sv ----
// self-checking bench for the flash sequencer over the register bus.
// assumes the array model on the strobe port; erase counts are shortened.
`timescale 1ns/1ps
`default_nettype none
module test_flash_program_erase_control;
   logic clk, rst_n, rd, wr, wreq, irq;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, q, d, pd, cnt, mdat, adat;
   logic [13:0] a, aofs, mofs;
   logic [3:0] stb;
   logic [7:0] exp_cnt [4];
   int miscompares, compares, op;
   flash_program_erase_control #(.PAGE_ERASE_COUNT(40),
      .FULL_ERASE_COUNT(60)) u_flash_program_erase_control (.i_clk(clk),
      .i_rst_n(rst_n), .i_ce(1'b1), .i_address(adr), .i_read(rd),
      .i_write(wr), .i_byteenable(4'hf), .i_writedata(wdat),
      .o_readdata(rdat), .o_waitrequest(wreq), .o_arr_program(stb[0]),
      .o_arr_page_erase(stb[1]), .o_arr_full_erase(stb[2]),
      .o_arr_commit(stb[3]), .o_arr_offset(aofs), .o_arr_data(adat),
      .o_irq(irq));
   flash_array_model u_flash_array_model (.i_clk(clk), .i_rst_n(rst_n),
      .i_strobe(stb), .i_offset(aofs), .i_data(adat), .o_counts(cnt),
      .o_offset(mofs), .o_data(mdat));
   function automatic logic [31:0] counts_exp();
      return {exp_cnt[3], exp_cnt[2], exp_cnt[1], exp_cnt[0]};
   endfunction
   function automatic logic [31:0] cmd_word(input int k);
      return {flash_ctl_pkg::COMMAND_KEY, 16'((1 << k) & 15)};
   endfunction
   task automatic end_of_test();
      if (miscompares == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %h %h", $time, seen, exp);
      end
   endtask
   // one full avalon cycle; read data is taken mid-cycle, half a clock before the releasing edge
   task automatic bus(input logic r, input logic [7:0] ad, logic [31:0] v);
      int n;
      n = 0;
      @(posedge clk);
      rd <= r;
      wr <= !r;
      adr <= ad;
      wdat <= v;
      // waitrequest is looked at mid-cycle, where it has settled
      do begin
         @(negedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 64);
      q = rdat;
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 64) begin
         miscompares++;
         end_of_test();
      end
   endtask
   task automatic poll(input int b);
      int n;
      n = 0;
      do begin
         bus(1'b1, flash_ctl_pkg::OFS_COMMAND, '0);
         n++;
      end while (q[b] !== 1'b0 && n < 1000);
      if (n >= 1000) begin
         miscompares++;
         end_of_test();
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      adr = '0;
      wdat = '0;
      pd = '0;
      miscompares = 0;
      compares = 0;
      exp_cnt = '{default: 8'h00};
      // fixed seed, so the random addresses and data repeat from run to run
      void'($urandom(32'hc822_67bf));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, 8'h20, 32'hffff_ffff);
      for (int r = 0; r < 9; r++) begin
         bus(1'b1, 8'(r * 4), '0);
         check(q, '0);
      end
      for (int n = 0; n < 8; n++) begin
         op = n % 4;
         a = 14'($urandom) & (op == 1 ? ~flash_ctl_pkg::PAGE_ALIGN_MASK
            : ~flash_ctl_pkg::WORD_ALIGN_MASK);
         d = $urandom;
         if (n == 4) begin
            bus(1'b0, flash_ctl_pkg::OFS_IRQ_MASK, 32'h0000_0002);
         end
         bus(1'b0, flash_ctl_pkg::OFS_TARGET_ADDRESS, {18'($urandom), a});
         bus(1'b1, flash_ctl_pkg::OFS_TARGET_ADDRESS, '0);
         check(q, {18'h0, a});
         bus(1'b0, flash_ctl_pkg::OFS_WRITE_DATA, d);
         bus(1'b1, flash_ctl_pkg::OFS_WRITE_DATA, '0);
         check(q, d);
         bus(1'b0, flash_ctl_pkg::OFS_COMMAND, cmd_word(op));
         exp_cnt[op]++;
         bus(1'b1, flash_ctl_pkg::OFS_COMMAND, '0);
         check(q, 32'(1 << op));
         bus(1'b0, flash_ctl_pkg::OFS_COMMAND, cmd_word(4));
         bus(1'b0, flash_ctl_pkg::OFS_COMMAND, cmd_word((op + 1) % 4));
         bus(1'b1, flash_ctl_pkg::OFS_COMMAND, '0);
         check(q, 32'(1 << op));
         poll(op);
         check(cnt, counts_exp());
         if (op == 0) begin
            pd = d;
         end
         if (op < 2) begin
            check(32'(mofs), 32'(a));
         end
         check(mdat, pd);
         bus(1'b1, flash_ctl_pkg::OFS_RAW_STATUS, '0);
         check(q, 32'(op != 3) << 1);
         check(32'(irq), 32'(op != 3 && n >= 4));
         bus(1'b0, flash_ctl_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
         bus(1'b1, flash_ctl_pkg::OFS_RAW_STATUS, '0);
         check(q, '0);
         check(32'(irq), '0);
      end
      bus(1'b0, flash_ctl_pkg::OFS_COMMAND, 32'h5aa5_0001);
      bus(1'b1, flash_ctl_pkg::OFS_COMMAND, '0);
      check(q, '0);
      check(cnt, counts_exp());
      end_of_test();
   end
endmodule
`default_nettype wire
